/* src/brownout_map.vh */
// register offsets, field values and timing counts of the supply brown-out monitor
`ifndef BROWNOUT_MAP_VH
`define BROWNOUT_MAP_VH

`define MODE_CTRL_ADDR      4'h0
`define THRESH_SEL_ADDR     4'h1
`define MON_LEVEL_ADDR      4'h8
`define MON_IRQ_CTRL_ADDR   4'h9
`define MON_IRQ_FLAGS_ADDR  4'ha
`define MON_STATE_ADDR      4'hb

`define MODE_DISABLED       2'h0
`define MODE_CONTINUOUS     2'h1
`define MODE_SAMPLED        2'h2
`define MODE_CONT_HALT      2'h3

`define TRIG_BELOW          2'h0
`define TRIG_ABOVE          2'h1
`define TRIG_CROSS          2'h2

`define UNLOCK_WINDOW       3'h4

`define CLK_HZ              100000000
`define RATE_FAST_HZ        1000
`define RATE_SLOW_HZ        125
`define FAST_PERIOD_CYC     (`CLK_HZ / `RATE_FAST_HZ)
`define SLOW_PERIOD_CYC     (`CLK_HZ / `RATE_SLOW_HZ)
`define SAMPLE_ON_CYC       20'h0000a

`endif

/* src/supply_brownout_monitor.v */
// digital control of a brown-out detector and its early-warning level monitor
`include "brownout_map.vh"

module supply_brownout_monitor (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire [3:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   input  wire       fuse_load_i,
   input  wire [2:0] fuse_threshold_i,
   input  wire       fuse_rate_i,
   input  wire [1:0] fuse_active_mode_i,
   input  wire [1:0] fuse_sleep_mode_i,
   input  wire       unlock_key_i,
   input  wire       instr_retire_i,
   input  wire       deep_sleep_i,
   input  wire       debug_halt_i,
   input  wire       below_threshold_i,
   input  wire       below_monitor_i,
   output reg  [2:0] threshold_level_o,
   output reg  [1:0] monitor_level_o,
   output reg        detector_power_o,
   output reg        monitor_power_o,
   output reg        cpu_hold_o,
   output reg        sys_reset_o,
   output reg        irq_o
);

   localparam [31:0] FAST_FULL = `FAST_PERIOD_CYC;
   localparam [31:0] SLOW_FULL = `SLOW_PERIOD_CYC;
   localparam [26:0] FAST_CYC  = FAST_FULL[26:0];
   localparam [26:0] SLOW_CYC  = SLOW_FULL[26:0];
   localparam [26:0] ON_CYC   = {7'h00, `SAMPLE_ON_CYC};

   // ---------------------------------------------------------------
   // configuration, status and internal state registers
   // ---------------------------------------------------------------
   reg       rate_reg;
   reg [1:0] active_mode_reg;
   reg [1:0] sleep_mode_reg;
   reg [2:0] threshold_reg;
   reg [1:0] level_reg;
   reg [1:0] trigger_reg;
   reg       irq_en_reg;
   reg       flag_reg;
   reg       state_reg;
   reg       prev_below_reg;
   reg       seen_reg;
   reg [2:0] unlock_cnt_reg;
   reg [26:0] tick_reg;
   reg       ready_reg;
   // comparator outputs are meaningful only once the power seen last edge was on
   reg       det_ok_reg;
   reg       mon_ok_reg;

   wire [1:0] cur_mode = deep_sleep_i ? sleep_mode_reg : active_mode_reg;
   wire       det_on   = (cur_mode != `MODE_DISABLED) &&
                         !(deep_sleep_i && cur_mode == `MODE_CONT_HALT);
   wire       sampled  = (cur_mode == `MODE_SAMPLED);
   wire [26:0] period  = rate_reg ? SLOW_CYC : FAST_CYC;
   wire       window_on = !sampled || (tick_reg < ON_CYC);
   wire       sample_pt = sampled ? (tick_reg == ON_CYC - 27'h1) : 1'b1;
   wire       mon_on   = det_on && irq_en_reg;
   wire       mon_eval = mon_on && sample_pt && mon_ok_reg;
   wire       wr_sel   = wr_i && (addr_i == `MODE_CTRL_ADDR);
   wire       unlocked = (unlock_cnt_reg != 3'h0);

   function trig_hit;
      input [1:0] cfg;
      input       prev;
      input       now;
      begin
         case (cfg)
            `TRIG_BELOW: trig_hit = !prev && now;
            `TRIG_ABOVE: trig_hit = prev && !now;
            `TRIG_CROSS: trig_hit = prev != now;
            default:     trig_hit = 1'b0;
         endcase
      end
   endfunction

   wire event_set = mon_eval && seen_reg && trig_hit(trigger_reg, prev_below_reg, below_monitor_i);

   // ---------------------------------------------------------------
   // register writes and monitor state
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rate_reg        <= 1'b0;
         active_mode_reg <= 2'h0;
         sleep_mode_reg  <= 2'h0;
         threshold_reg   <= 3'h0;
         level_reg       <= 2'h0;
         trigger_reg     <= 2'h0;
         irq_en_reg      <= 1'b0;
         flag_reg        <= 1'b0;
         state_reg       <= 1'b0;
         prev_below_reg  <= 1'b0;
         seen_reg        <= 1'b0;
         unlock_cnt_reg  <= 3'h0;
         tick_reg        <= 27'h0;
      end else if (fuse_load_i) begin
         rate_reg        <= fuse_rate_i;
         active_mode_reg <= fuse_active_mode_i;
         sleep_mode_reg  <= fuse_sleep_mode_i;
         threshold_reg   <= fuse_threshold_i;
         unlock_cnt_reg  <= 3'h0;
         seen_reg        <= 1'b0;
         tick_reg        <= 27'h0;
      end else begin
         // unlock counts down over retired instructions
         if (unlock_key_i)
            unlock_cnt_reg <= `UNLOCK_WINDOW;
         else if (wr_sel)
            unlock_cnt_reg <= 3'h0;
         else if (unlocked && instr_retire_i)
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
         // active mode, threshold and rate have no write path
         if (wr_sel && unlocked && wdata_i[1:0] != `MODE_CONT_HALT)
            sleep_mode_reg <= wdata_i[1:0];
         if (wr_i && addr_i == `MON_LEVEL_ADDR)
            level_reg <= wdata_i[1:0];
         if (wr_i && addr_i == `MON_IRQ_CTRL_ADDR) begin
            trigger_reg <= wdata_i[2:1];
            irq_en_reg  <= wdata_i[0];
         end
         if (event_set)
            flag_reg <= 1'b1;
         else if (wr_i && addr_i == `MON_IRQ_FLAGS_ADDR && wdata_i[0])
            flag_reg <= 1'b0;
         if (mon_eval)
            state_reg <= below_monitor_i;
         if (mon_eval) begin
            prev_below_reg <= below_monitor_i;
            seen_reg       <= 1'b1;
         end else if (!mon_on)
            seen_reg <= 1'b0;
         if (!sampled || tick_reg >= period - 27'h1)
            tick_reg <= 27'h0;
         else
            tick_reg <= tick_reg + 27'h1;
      end
   end

   // ---------------------------------------------------------------
   // outputs and read port
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o           <= 8'h00;
         threshold_level_o <= 3'h0;
         monitor_level_o   <= 2'h0;
         detector_power_o  <= 1'b0;
         monitor_power_o   <= 1'b0;
         cpu_hold_o        <= 1'b0;
         sys_reset_o       <= 1'b0;
         irq_o             <= 1'b0;
         ready_reg         <= 1'b0;
         det_ok_reg        <= 1'b0;
         mon_ok_reg        <= 1'b0;
      end else begin
         det_ok_reg        <= detector_power_o;
         mon_ok_reg        <= monitor_power_o;
         threshold_level_o <= threshold_reg;
         monitor_level_o   <= level_reg;
         detector_power_o  <= det_on && window_on;
         monitor_power_o   <= mon_on && window_on;
         ready_reg         <= det_on && !deep_sleep_i;
         cpu_hold_o        <= !deep_sleep_i && active_mode_reg == `MODE_CONT_HALT && !ready_reg;
         sys_reset_o       <= det_on && sample_pt && det_ok_reg && below_threshold_i;
         irq_o             <= flag_reg && irq_en_reg && !debug_halt_i;
         rdata_o           <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               `MODE_CTRL_ADDR:     rdata_o <= {3'h0, rate_reg, active_mode_reg, sleep_mode_reg};
               `THRESH_SEL_ADDR:    rdata_o <= {5'h00, threshold_reg};
               `MON_LEVEL_ADDR:     rdata_o <= {6'h00, level_reg};
               `MON_IRQ_CTRL_ADDR:  rdata_o <= {5'h00, trigger_reg, irq_en_reg};
               `MON_IRQ_FLAGS_ADDR: rdata_o <= {7'h00, flag_reg};
               `MON_STATE_ADDR:     rdata_o <= {7'h00, state_reg};
               default:             rdata_o <= 8'h00;
            endcase
         end
      end
   end

endmodule // supply_brownout_monitor

/* test/sbm_chk.sv */
// assertions on the ports of the supply brown-out monitor
module sbm_chk (
   input wire       clk_i, rst_n_i, wr_i, rd_i, fuse_load_i, debug_halt_i, below_threshold_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i, rdata_o,
   input wire [2:0] fuse_threshold_i, threshold_level_o,
   input wire [1:0] monitor_level_o,
   input wire       detector_power_o, monitor_power_o, sys_reset_o, irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_lvl_wr;
      wr_i && addr_i == 4'h8 && wdata_i[1:0] != 2'h3;
   endsequence
   sequence s_irq_quiet;
      irq_o && !debug_halt_i && !(wr_i && (addr_i == 4'h9 || addr_i == 4'ha)) &&
      !$past(wr_i && (addr_i == 4'h9 || addr_i == 4'ha));
   endsequence
   a_rdata_idle:   assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
   a_debug_gate:   assert property (debug_halt_i && $past(debug_halt_i) |-> !irq_o) else $error("irq in debug");
   a_irq_holds:    assert property (s_irq_quiet |=> irq_o) else $error("irq dropped early");
   a_fuse_load:    assert property (fuse_load_i ##1 !fuse_load_i |=> threshold_level_o == $past(fuse_threshold_i, 2))
      else $error("no load");
   a_thresh_fixed: assert property (!$past(fuse_load_i) && !$past(fuse_load_i, 2) |-> $stable(threshold_level_o))
      else $error("level moved");
   a_mon_needs_det: assert property (monitor_power_o |-> detector_power_o) else $error("monitor alone");
   a_reset_cause:  assert property ($rose(sys_reset_o) |-> $past(below_threshold_i) || $past(below_threshold_i, 2))
      else $error("reset without cause");
   a_level_write:  assert property (s_lvl_wr |=> ##1 monitor_level_o == $past(wdata_i[1:0], 2))
      else $error("level lost");
endmodule // sbm_chk
bind supply_brownout_monitor sbm_chk chk (.*);

/* test/supply_model.sv */
// behavioural supply comparators facing the brown-out monitor
module supply_model (
   input  wire       clk_i,
   input  int        vdd_mv,
   input  wire [2:0] thr_code,
   input  wire [1:0] lvl_code,
   input  wire       det_pwr,
   input  wire       mon_pwr,
   output logic      below_thr,
   output logic      below_mon
);
   timeunit 1ns;
   timeprecision 1ps;
   int thr_mv, mon_mv;
   initial begin
      below_thr = 1'b0;
      below_mon = 1'b0;
   end
   always_comb begin
      thr_mv = (thr_code == 3'h0) ? 1800 : (thr_code == 3'h2) ? 2600 : 4200;
      mon_mv = thr_mv * (105 + 10 * int'(lvl_code)) / 100;
   end
   // an unpowered comparator gives no meaning, so it wobbles
   always @(posedge clk_i) begin
      below_thr <= det_pwr ? (vdd_mv < thr_mv) : !below_thr;
      below_mon <= mon_pwr ? (vdd_mv < mon_mv) : !below_mon;
   end
endmodule // supply_model

/* test/tb_top.sv */
// testbench of the supply brown-out monitor
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, fuse_load_i = 0, unlock_key_i = 0;
   logic       instr_retire_i = 0, deep_sleep_i = 0, debug_halt_i = 0, below_threshold_i, below_monitor_i;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic [2:0] threshold_level_o;
   logic [1:0] monitor_level_o;
   logic       detector_power_o, monitor_power_o, cpu_hold_o, sys_reset_o, irq_o;
   int         vdd_mv = 3300, err_total = 0, samples_checked = 0, cycles = 0;
   supply_brownout_monitor DUT (.*, .fuse_threshold_i(3'h2), .fuse_rate_i(1'b0), .fuse_active_mode_i(2'h1),
      .fuse_sleep_mode_i(2'h1));
   supply_model PM (.clk_i, .vdd_mv, .thr_code(threshold_level_o), .lvl_code(monitor_level_o),
      .det_pwr(detector_power_o), .mon_pwr(monitor_power_o), .below_thr(below_threshold_i),
      .below_mon(below_monitor_i));
   initial forever #5 clk_i = ~clk_i;
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_chk(logic [3:0] a, logic [7:0] e, string n);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(n, e, rdata_o);
   endtask
   task automatic unlock(int n);
      @(posedge clk_i) unlock_key_i <= 1'b1;
      @(posedge clk_i) unlock_key_i <= 1'b0;
      repeat (n) begin
         @(posedge clk_i) instr_retire_i <= 1'b1;
         @(posedge clk_i) instr_retire_i <= 1'b0;
      end
   endtask
   task automatic t_regs;
      rd_chk(4'h0, 8'h05, "mode");
      wr_reg(4'h1, 8'h07);
      rd_chk(4'h1, 8'h02, "thresh");
      for (int a = 2; a < 12; a++) rd_chk(a[3:0], 8'h00, "reset");
      $display("t_regs done");
   endtask
   task automatic t_unlock;
      wr_reg(4'h0, 8'h00);
      rd_chk(4'h0, 8'h05, "locked");
      unlock(5);
      wr_reg(4'h0, 8'h00);
      rd_chk(4'h0, 8'h05, "late");
      unlock(1);
      wr_reg(4'h0, 8'h10);
      rd_chk(4'h0, 8'h04, "unlocked");
      $display("t_unlock done");
   endtask
   task automatic t_sleep;
      deep_sleep_i <= 1'b1;
      tick(4);
      chk("det off", 8'h00, {7'h0, detector_power_o});
      chk("mon off", 8'h00, {7'h0, monitor_power_o});
      deep_sleep_i <= 1'b0;
      tick(4);
      chk("det on", 8'h01, {7'h0, detector_power_o});
      $display("t_sleep done");
   endtask
   task automatic t_monitor;
      wr_reg(4'h8, 8'h01);
      rd_chk(4'h8, 8'h01, "level");
      wr_reg(4'h9, 8'h01);
      tick(4);
      vdd_mv <= 2800;
      tick(4);
      rd_chk(4'ha, 8'h01, "below");
      rd_chk(4'hb, 8'h01, "state");
      chk("irq", 8'h01, {7'h0, irq_o});
      debug_halt_i <= 1'b1;
      tick(3);
      chk("irq dbg", 8'h00, {7'h0, irq_o});
      debug_halt_i <= 1'b0;
      wr_reg(4'ha, 8'h00);
      rd_chk(4'ha, 8'h01, "w0");
      wr_reg(4'ha, 8'h01);
      rd_chk(4'ha, 8'h00, "w1");
      chk("irq clr", 8'h00, {7'h0, irq_o});
      wr_reg(4'h9, 8'h03);
      vdd_mv <= 3300;
      tick(4);
      rd_chk(4'ha, 8'h01, "above");
      wr_reg(4'ha, 8'h01);
      wr_reg(4'h9, 8'h05);
      vdd_mv <= 2800;
      tick(4);
      rd_chk(4'ha, 8'h01, "cross");
      vdd_mv <= 2500;
      tick(4);
      chk("reset", 8'h01, {7'h0, sys_reset_o});
      vdd_mv <= 3300;
      $display("t_monitor done");
   endtask
   initial begin
      tick(5);
      rst_n_i <= 1'b1;
      @(posedge clk_i) fuse_load_i <= 1'b1;
      tick(2);
      fuse_load_i <= 1'b0;
      tick(2);
      t_regs;
      t_unlock;
      t_sleep;
      t_monitor;
      report_and_stop;
   end
endmodule // tb_top
